// ### hdl/csg_pkg.sv
// package: constants for the channel sequencer and gate keying block
package csg_pkg;
   localparam int          CSG_CHANNELS      = 8;
   localparam int          CSG_VIDEO_W       = 9;
   localparam int          CSG_CLK_NS        = 20;
   localparam int          CSG_DELAY_MIN_NS  = 4000;
   localparam int          CSG_DELAY_MAX_NS  = 25000;
   localparam int          CSG_DELAY_MIN_CYC = (CSG_DELAY_MIN_NS + CSG_CLK_NS - 1) / CSG_CLK_NS;
   localparam int          CSG_DELAY_MAX_CYC = CSG_DELAY_MAX_NS / CSG_CLK_NS;
   localparam int          CSG_DELAY_W       = 11;
   localparam int          CSG_DIV_RATIO     = 8;
   localparam int          CSG_DIV_W         = 3;
   localparam logic [7:0]  CSG_SEQ_RST       = 8'h01;
   localparam logic [2:0]  CSG_DIV_RST       = 3'h0;
   localparam logic [10:0] CSG_DELAY_RST     = 11'h000;
   typedef enum logic {CSG_DLY_IDLE, CSG_DLY_RUN} csg_dly_state_type;
endpackage

// ### hdl/csg_sequencer.sv
// eight-step one-hot pulse sequencer
`timescale 1ns/1ps
module csg_sequencer
   import csg_pkg::*;
(
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    resetn,
   // control
   input  wire logic                    trigger,
   input  wire logic                    phase_reset,
   // channel outputs
   output logic [CSG_CHANNELS-1:0]      chan_r
);
   logic [CSG_CHANNELS-1:0] chan_nxt;

   always_comb begin
      chan_nxt = chan_r;
      if (phase_reset) begin
         chan_nxt = CSG_SEQ_RST;
      end else if (trigger) begin
         chan_nxt = {chan_r[CSG_CHANNELS-2:0], chan_r[CSG_CHANNELS-1]};
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chan_r <= CSG_SEQ_RST;
      end else begin
         chan_r <= chan_nxt;
      end
   end

   property p_onehot;
      @(posedge clk_sys) disable iff (!resetn) $onehot(chan_r);
   endproperty
   a_onehot: assert property (p_onehot) else $error("sequencer not one-hot");

   property p_advance;
      @(posedge clk_sys) disable iff (!resetn)
         (trigger && !phase_reset) |=> (chan_r == {$past(chan_r[CSG_CHANNELS-2:0]), $past(chan_r[CSG_CHANNELS-1])});
   endproperty
   a_advance: assert property (p_advance) else $error("sequencer did not advance");

   property p_phase;
      @(posedge clk_sys) disable iff (!resetn) phase_reset |=> chan_r == CSG_SEQ_RST;
   endproperty
   a_phase: assert property (p_phase) else $error("phase reset not to channel 1");

   property p_hold;
      @(posedge clk_sys) disable iff (!resetn) (!trigger && !phase_reset) |=> $stable(chan_r);
   endproperty
   a_hold: assert property (p_hold) else $error("sequencer moved without trigger");
endmodule

// ### hdl/csg_top.sv
// top: sequencer, coincidence gates, data gates and sync delay
// How it works
// - eight channel pulses in strict order, one active per step, decoded by coincidence.
// - each trigger pulse advances the sequencer one channel unless a reset pulse comes in the same cycle.
// - reset pulse forces sequencer to channel 1 phase.
// - coincidence gate output asserted only while both inputs asserted.
// - group select one feeds gates 1-4, group select two feeds gates 5-8.
// - other gate input is matching sequencer channel; each gate keys one data gate.
// - open data gate passes video sample to its channel output.
// - closed data gate holds its channel output at zero.
// - sync delay path delays a data sync pulse taken while idle by 4 to 25 us; syncs during a delay are ignored.
// - after the delay a single positive converter command pulse is emitted.
// - in vibration mode low-speed sequencer triggers on data sync divided by eight.
`timescale 1ns/1ps
module csg_top
   import csg_pkg::*;
(
   // clock and reset
   input  wire logic                      clk_sys,
   input  wire logic                      resetn,
   // sync inputs
   input  wire logic                      data_sync,
   input  wire logic                      frame_sync,
   input  wire logic                      vibration_mode,
   // group selects
   input  wire logic                      group_lo_sel,
   input  wire logic                      group_hi_sel,
   // video
   input  wire logic [CSG_VIDEO_W-1:0]    video_in,
   // delay setting in clock cycles
   input  wire logic [CSG_DELAY_W-1:0]    delay_cycles,
   // outputs
   output logic [CSG_CHANNELS-1:0]        key_r,
   output logic [CSG_VIDEO_W-1:0]         chan_out_r [CSG_CHANNELS],
   output logic                           convert_cmd_r
);
   logic [CSG_CHANNELS-1:0] seq_chan;
   logic [CSG_DIV_W-1:0]    div_r;
   logic [CSG_DIV_W-1:0]    div_nxt;
   logic                    seq_trigger;
   logic [CSG_CHANNELS-1:0] key_nxt;
   logic [CSG_VIDEO_W-1:0]  chan_out_nxt [CSG_CHANNELS];
   csg_dly_state_type       dly_state_r;
   csg_dly_state_type       dly_state_nxt;
   logic [CSG_DELAY_W-1:0]  dly_cnt_r;
   logic [CSG_DELAY_W-1:0]  dly_cnt_nxt;
   logic [CSG_DELAY_W-1:0]  dly_target;
   logic                    convert_cmd_nxt;
   logic                    chk_wait_r;
   logic                    chk_wait_nxt;
   logic [CSG_DELAY_W-1:0]  chk_cnt_r;
   logic [CSG_DELAY_W-1:0]  chk_cnt_nxt;

   // divide-by-eight trigger for vibration operation
   always_comb begin
      div_nxt = div_r;
      if (frame_sync) begin
         div_nxt = CSG_DIV_RST;
      end else if (data_sync) begin
         div_nxt = div_r + 3'h1;
      end
      seq_trigger = vibration_mode ? (data_sync && div_r == 3'(CSG_DIV_RATIO - 1)) : data_sync;
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_r <= CSG_DIV_RST;
      end else begin
         div_r <= div_nxt;
      end
   end

   csg_sequencer u_seq (
      .clk_sys     (clk_sys),
      .resetn      (resetn),
      .trigger     (seq_trigger),
      .phase_reset (frame_sync),
      .chan_r      (seq_chan)
   );

   // coincidence gates and data gates
   always_comb begin
      for (int i = 0; i < CSG_CHANNELS; i++) begin
         key_nxt[i] = seq_chan[i] && ((i < 4) ? group_lo_sel : group_hi_sel);
         chan_out_nxt[i] = key_nxt[i] ? video_in : '0;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         key_r <= '0;
         for (int i = 0; i < CSG_CHANNELS; i++) begin
            chan_out_r[i] <= '0;
         end
      end else begin
         key_r <= key_nxt;
         chan_out_r <= chan_out_nxt;
      end
   end

   // sync delay to converter command
   always_comb begin
      if (delay_cycles < CSG_DELAY_W'(CSG_DELAY_MIN_CYC)) begin
         dly_target = CSG_DELAY_W'(CSG_DELAY_MIN_CYC);
      end else if (delay_cycles > CSG_DELAY_W'(CSG_DELAY_MAX_CYC)) begin
         dly_target = CSG_DELAY_W'(CSG_DELAY_MAX_CYC);
      end else begin
         dly_target = delay_cycles;
      end
      dly_state_nxt = dly_state_r;
      dly_cnt_nxt = dly_cnt_r;
      convert_cmd_nxt = 1'b0;
      unique case (dly_state_r)
         CSG_DLY_IDLE: begin
            if (data_sync) begin
               dly_state_nxt = CSG_DLY_RUN;
               dly_cnt_nxt = CSG_DELAY_W'(1);
            end
         end
         CSG_DLY_RUN: begin
            if (dly_cnt_r >= dly_target) begin
               convert_cmd_nxt = 1'b1;
               dly_state_nxt = CSG_DLY_IDLE;
               dly_cnt_nxt = CSG_DELAY_RST;
            end else begin
               dly_cnt_nxt = dly_cnt_r + 11'h001;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         dly_state_r <= CSG_DLY_IDLE;
         dly_cnt_r <= CSG_DELAY_RST;
         convert_cmd_r <= 1'b0;
      end else begin
         dly_state_r <= dly_state_nxt;
         dly_cnt_r <= dly_cnt_nxt;
         convert_cmd_r <= convert_cmd_nxt;
      end
   end

   sequence s_sync_start;
      data_sync && dly_state_r == CSG_DLY_IDLE;
   endsequence

   property p_cmd_min;
      @(posedge clk_sys) disable iff (!resetn) s_sync_start |=> !convert_cmd_r [*8];
   endproperty
   a_cmd_min: assert property (p_cmd_min) else $error("command pulse too early");

   // watchdog counting cycles from a taken sync to its command pulse
   always_comb begin
      chk_wait_nxt = chk_wait_r;
      chk_cnt_nxt = chk_cnt_r;
      if (data_sync && dly_state_r == CSG_DLY_IDLE) begin
         chk_wait_nxt = 1'b1;
         chk_cnt_nxt = CSG_DELAY_W'(1);
      end else if (chk_wait_r && convert_cmd_r) begin
         chk_wait_nxt = 1'b0;
         chk_cnt_nxt = CSG_DELAY_RST;
      end else if (chk_wait_r && chk_cnt_r != '1) begin
         chk_cnt_nxt = chk_cnt_r + 11'h001;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chk_wait_r <= 1'b0;
         chk_cnt_r <= CSG_DELAY_RST;
      end else begin
         chk_wait_r <= chk_wait_nxt;
         chk_cnt_r <= chk_cnt_nxt;
      end
   end

   property p_cmd_max;
      @(posedge clk_sys) disable iff (!resetn) (chk_wait_r && !convert_cmd_r) |-> chk_cnt_r <= CSG_DELAY_MAX_CYC;
   endproperty
   a_cmd_max: assert property (p_cmd_max) else $error("command pulse missing");

   property p_cmd_early_cnt;
      @(posedge clk_sys) disable iff (!resetn) (chk_wait_r && convert_cmd_r) |-> chk_cnt_r > CSG_DELAY_MIN_CYC;
   endproperty
   a_cmd_early_cnt: assert property (p_cmd_early_cnt) else $error("command pulse before minimum delay");

   property p_cmd_single;
      @(posedge clk_sys) disable iff (!resetn) convert_cmd_r |=> !convert_cmd_r;
   endproperty
   a_cmd_single: assert property (p_cmd_single) else $error("command pulse not single");

   property p_key_and;
      @(posedge clk_sys) disable iff (!resetn)
         $past(resetn) |-> key_r == ($past(seq_chan) & {{4{$past(group_hi_sel)}}, {4{$past(group_lo_sel)}}});
   endproperty
   a_key_and: assert property (p_key_and) else $error("coincidence gate mismatch");

   property p_key_onehot;
      @(posedge clk_sys) disable iff (!resetn) $onehot0(key_r);
   endproperty
   a_key_onehot: assert property (p_key_onehot) else $error("two keys at once");

   property p_open;
      @(posedge clk_sys) disable iff (!resetn) key_r[2] |-> chan_out_r[2] == $past(video_in);
   endproperty
   a_open: assert property (p_open) else $error("open gate did not pass video");

   property p_closed;
      @(posedge clk_sys) disable iff (!resetn) !key_r[5] |-> chan_out_r[5] == '0;
   endproperty
   a_closed: assert property (p_closed) else $error("closed gate not zero");

   property p_div;
      @(posedge clk_sys) disable iff (!resetn)
         (vibration_mode && data_sync && !frame_sync && div_r != 3'h7) |-> !seq_trigger;
   endproperty
   a_div: assert property (p_div) else $error("divided trigger too frequent");

   property p_div_fire;
      @(posedge clk_sys) disable iff (!resetn)
         (vibration_mode && data_sync && div_r == 3'(CSG_DIV_RATIO - 1)) |-> seq_trigger;
   endproperty
   a_div_fire: assert property (p_div_fire) else $error("divided trigger missing");
endmodule

// ### testbench/csg_sync_far.sv
// far-side model: sync separator pulse sources
`timescale 1ns/1ps
module csg_sync_far (
   // clock
   input  wire logic clk_sys,
   // requests from the bench
   input  wire logic ds_req,
   input  wire logic fs_req,
   // sync pulses to the block
   output logic      data_sync,
   output logic      frame_sync
);
   logic fs_d;
   initial begin
      data_sync  = 1'b0;
      frame_sync = 1'b0;
      fs_d       = 1'b0;
   end
   // frame sync one cycle behind data sync
   always @(posedge clk_sys) begin
      data_sync  <= ds_req;
      fs_d       <= fs_req;
      frame_sync <= fs_d;
   end
endmodule

// ### testbench/channel_sequencer_gate_keying_tb.sv
// self-checking bench for the sequencer and gate keying block
`timescale 1ns/1ps
module channel_sequencer_gate_keying_tb;
   import csg_pkg::*;
   logic                    clk_sys, resetn, ds_req, fs_req, data_sync, frame_sync;
   logic                    vibration_mode, group_lo_sel, group_hi_sel, convert_cmd_r;
   logic [CSG_VIDEO_W-1:0]  video_in;
   logic [CSG_DELAY_W-1:0]  delay_cycles;
   logic [CSG_CHANNELS-1:0] key_r;
   logic [CSG_VIDEO_W-1:0]  chan_out_r [CSG_CHANNELS];
   int                      failures, num_checks, cycles;

   csg_sync_far i_far (.clk_sys(clk_sys), .ds_req(ds_req), .fs_req(fs_req),
      .data_sync(data_sync), .frame_sync(frame_sync));
   csg_top i_dut (.clk_sys(clk_sys), .resetn(resetn), .data_sync(data_sync),
      .frame_sync(frame_sync), .vibration_mode(vibration_mode), .group_lo_sel(group_lo_sel),
      .group_hi_sel(group_hi_sel), .video_in(video_in), .delay_cycles(delay_cycles),
      .key_r(key_r), .chan_out_r(chan_out_r), .convert_cmd_r(convert_cmd_r));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic close_out;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 'h4E20) begin
         failures++;
         close_out();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // one-cycle data sync request, with frame sync as well if f
   task automatic req(input logic f);
      @(posedge clk_sys) begin
         ds_req <= 1'b1;
         fs_req <= f;
      end
      @(posedge clk_sys) begin
         ds_req <= 1'b0;
         fs_req <= 1'b0;
      end
   endtask

   task automatic t_keys;
      logic [7:0] exp;
      logic [8:0] vid;
      for (int ch = 0; ch < 9; ch++) begin
         for (int s = 0; s < 4; s++) begin
            vid = 9'(ch) * 9'h025 + 9'(s) + 9'h001;
            @(posedge clk_sys) begin
               group_lo_sel <= s[0];
               group_hi_sel <= s[1];
               video_in     <= vid;
            end
            wait_n(2);
            exp = (8'h01 << (ch % 8)) & {{4{s[1]}}, {4{s[0]}}};
            chk(16'(key_r), 16'(exp));
            for (int j = 0; j < 8; j++) begin
               chk(16'(chan_out_r[j]), exp[j] ? 16'(vid) : 16'h0000);
            end
         end
         req(1'b0);
         wait_n(3);
      end
      $display("sequence and keying test done");
   endtask

   task automatic t_reset;
      repeat (3) req(1'b0);
      wait_n(3);
      chk(16'(key_r), 16'h0010);
      req(1'b1);
      wait_n(4);
      chk(16'(key_r), 16'h0001);
      $display("phase reset test done");
   endtask

   task automatic t_vib;
      @(posedge clk_sys) vibration_mode <= 1'b1;
      req(1'b1);
      wait_n(4);
      repeat (7) req(1'b0);
      wait_n(3);
      chk(16'(key_r), 16'h0001);
      req(1'b0);
      wait_n(3);
      chk(16'(key_r), 16'h0002);
      @(posedge clk_sys) vibration_mode <= 1'b0;
      $display("divided trigger test done");
   endtask

   // sync taken, second sync mid-delay must be ignored
   task automatic t_delay(input logic [10:0] set, input int n);
      int hits;
      int at;
      hits = 0;
      at = 0;
      @(posedge clk_sys) delay_cycles <= set;
      wait_n('h514);
      req(1'b0);
      @(posedge clk_sys);
      for (int i = 1; i <= 2 * n + 2; i++) begin
         @(posedge clk_sys) ds_req <= (i == 'h32);
         #1;
         if (convert_cmd_r === 1'b1) begin
            hits++;
            at = i;
         end
      end
      chk(16'(hits), 16'h0001);
      chk(16'(at), 16'(n));
      $display("delay test done");
   endtask

   initial begin
      resetn = 1'b0;
      ds_req = 1'b0;
      fs_req = 1'b0;
      vibration_mode = 1'b0;
      group_lo_sel = 1'b1;
      group_hi_sel = 1'b1;
      video_in = 9'h000;
      delay_cycles = 11'h0C8;
      failures = 0;
      num_checks = 0;
      cycles = 0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      wait_n(2);
      chk(16'(key_r), 16'h0001);
      t_keys();
      t_reset();
      t_vib();
      t_delay(11'h0C8, CSG_DELAY_MIN_CYC);
      t_delay(11'h064, CSG_DELAY_MIN_CYC);
      t_delay(11'h1F4, 'h1F4);
      t_delay(11'h7D0, CSG_DELAY_MAX_CYC);
      close_out();
   end
endmodule
